// >>> rtl/clock_gate_pkg.sv
package clock_gate_pkg;

  localparam int unsigned REG_WIDTH = 16;

  // Word offset of the clock enable register in its peripheral frame
  localparam logic [5:0] PERIPHERAL_CLOCK_ENABLE_0_OFFSET = 6'h1C;
  localparam logic [15:0] PERIPHERAL_CLOCK_ENABLE_0_RESET = 16'h0000;
  // Writable bits: 15,14,11..6,4,3,2
  localparam logic [15:0] PERIPHERAL_CLOCK_ENABLE_0_WMASK = 16'hCFDC;

  localparam int unsigned PWM_TIMEBASE_CLOCK_SYNC_BIT = 2;
  localparam int unsigned CONVERTER_CLOCK_ENABLE_BIT = 3;
  localparam int unsigned TWO_WIRE_A_CLOCK_ENABLE_BIT = 4;
  localparam int unsigned SERIAL_PERIPH_C_CLOCK_ENABLE_BIT = 6;
  localparam int unsigned SERIAL_PERIPH_D_CLOCK_ENABLE_BIT = 7;
  localparam int unsigned SERIAL_PERIPH_A_CLOCK_ENABLE_BIT = 8;
  localparam int unsigned SERIAL_PERIPH_B_CLOCK_ENABLE_BIT = 9;
  localparam int unsigned SERIAL_COMM_A_CLOCK_ENABLE_BIT = 10;
  localparam int unsigned SERIAL_COMM_B_CLOCK_ENABLE_BIT = 11;
  localparam int unsigned CAN_A_CLOCK_ENABLE_BIT = 14;
  localparam int unsigned CAN_B_CLOCK_ENABLE_BIT = 15;

  // Read takes two wait states plus the access cycle; write none
  localparam int unsigned READ_WAIT_STATES = 2;
  localparam int unsigned READ_CYCLES = READ_WAIT_STATES + 1;
  localparam int unsigned WRITE_CYCLES = 1;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic        ready;
    logic [15:0] rdata;
  } bus_rsp_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } access_state_type;

endpackage

// >>> rtl/peripheral_clock_gating_register.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Bit 3 enables the clock to the converter, which runs only while the bit is one.
// - Bit 2 enables the PWM time-base clocks; clearing it stops them so setting it starts all together.
// - Bit 4 passes the system clock to the two-wire A controller only while it is one.
// - Bits 8, 9, 6 and 7 gate the low-speed clock to serial peripheral units A, B, C and D.
// - Bits 10 and 11 gate the low-speed clock to serial comm units A and B.
// - Bits 14 and 15 gate the system clock to CAN controllers A and B.
// - Enable bits are read/write and reset to zero; reserved bits read zero and ignore writes.
// - Protected registers ignore CPU writes while protection is armed.
// - The release instruction lets the CPU write protected registers; it must come first.
// - The restore instruction re-arms protection after the CPU has finished.
// - Reads take two wait states (three cycles), writes none (one cycle).
// - A new access stalls until the previous write has completed, keeping program order.
// - A read-modify-write takes six cycles: three read, latch, execute, write back.
// - A read-modify-write goes read, latch, modify, write, the next access after write-back.
module peripheral_clock_gating_register #(
  parameter int unsigned WIDTH = clock_gate_pkg::REG_WIDTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        low_speed_clock,
  input  wire logic                        protection_release,
  input  wire logic                        protection_restore,
  input  wire clock_gate_pkg::bus_req_type bus_req,
  output var  clock_gate_pkg::bus_rsp_type bus_rsp,
  output logic                             write_unlocked,
  output logic                             system_clock_output_can_a,
  output logic                             system_clock_output_can_b,
  output logic                             system_clock_output_two_wire_a,
  output logic                             converter_clock,
  output logic                             pwm_timebase_clock_run,
  output logic                             serial_periph_a_clock,
  output logic                             serial_periph_b_clock,
  output logic                             serial_periph_c_clock,
  output logic                             serial_periph_d_clock,
  output logic                             serial_comm_a_clock,
  output logic                             serial_comm_b_clock
);

  logic [WIDTH-1:0]                   enable_ff;
  logic [WIDTH-1:0]                   gate_sys_ff;
  logic [WIDTH-1:0]                   gate_low_ff;
  logic [WIDTH-1:0]                   gate_low_meta_ff;
  logic                               unlocked_ff;
  clock_gate_pkg::access_state_type   state_ff;
  clock_gate_pkg::access_state_type   nxt_state;
  logic [1:0]                         wait_ff;
  logic [1:0]                         nxt_wait;
  logic [WIDTH-1:0]                   rdata_ff;
  logic                               hit;
  logic                               write_ok;

  function automatic logic bit_of(input logic [WIDTH-1:0] v, input int unsigned idx);
    return v[idx];
  endfunction

  assign hit = (bus_req.addr == clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_OFFSET);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlocked_ff <= 1'b0;
    end else if (protection_release) begin
      unlocked_ff <= 1'b1;
    end else if (protection_restore) begin
      unlocked_ff <= 1'b0;
    end
  end

  assign write_unlocked = unlocked_ff;

  assign write_ok = (state_ff == clock_gate_pkg::ST_WRITE) && hit && unlocked_ff;

  // access sequencer: read waits, writes finish before next access
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    case (state_ff)
      clock_gate_pkg::ST_IDLE: begin
        if (bus_req.rd) begin
          nxt_state = clock_gate_pkg::ST_READ;
          nxt_wait  = 2'(clock_gate_pkg::READ_WAIT_STATES);
        end else if (bus_req.wr) begin
          nxt_state = clock_gate_pkg::ST_WRITE;
        end
      end
      clock_gate_pkg::ST_READ: begin
        if (wait_ff == 2'h0) begin
          nxt_state = clock_gate_pkg::ST_IDLE;
        end else begin
          nxt_wait = wait_ff - 2'h1;
        end
      end
      clock_gate_pkg::ST_WRITE: begin
        nxt_state = clock_gate_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = clock_gate_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= clock_gate_pkg::ST_IDLE;
      wait_ff  <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
    end
  end

  // ready on last read cycle or the write cycle
  always_comb begin
    bus_rsp.ready = ((state_ff == clock_gate_pkg::ST_READ) && (wait_ff == 2'h0))
                  || (state_ff == clock_gate_pkg::ST_WRITE);
    bus_rsp.rdata = rdata_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (bus_req.rd && state_ff == clock_gate_pkg::ST_IDLE) begin
      rdata_ff <= hit ? (enable_ff & clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK) : '0;
    end
  end

  // masked register store; write data held by CPU through the write cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_ff <= clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_RESET;
    end else if (write_ok) begin
      enable_ff <= bus_req.wdata & clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK;
    end
  end

  // latch enables while clock low: falling-edge flops avoid runt pulses
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      gate_sys_ff <= '0;
    end else begin
      gate_sys_ff <= enable_ff;
    end
  end

  // two flops into the slow domain; enable bits change on the fast clock
  always_ff @(negedge low_speed_clock or posedge rst) begin
    if (rst) begin
      gate_low_meta_ff <= '0;
      gate_low_ff      <= '0;
    end else begin
      gate_low_meta_ff <= enable_ff;
      gate_low_ff      <= gate_low_meta_ff;
    end
  end

  assign converter_clock = clk & bit_of(gate_sys_ff, clock_gate_pkg::CONVERTER_CLOCK_ENABLE_BIT);
  // time-base run level, all time bases start from one edge
  assign pwm_timebase_clock_run =
    bit_of(gate_sys_ff, clock_gate_pkg::PWM_TIMEBASE_CLOCK_SYNC_BIT);
  assign system_clock_output_two_wire_a =
    clk & bit_of(gate_sys_ff, clock_gate_pkg::TWO_WIRE_A_CLOCK_ENABLE_BIT);
  assign serial_periph_a_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_PERIPH_A_CLOCK_ENABLE_BIT);
  assign serial_periph_b_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_PERIPH_B_CLOCK_ENABLE_BIT);
  assign serial_periph_c_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_PERIPH_C_CLOCK_ENABLE_BIT);
  assign serial_periph_d_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_PERIPH_D_CLOCK_ENABLE_BIT);
  assign serial_comm_a_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_COMM_A_CLOCK_ENABLE_BIT);
  assign serial_comm_b_clock =
    low_speed_clock & bit_of(gate_low_ff, clock_gate_pkg::SERIAL_COMM_B_CLOCK_ENABLE_BIT);
  assign system_clock_output_can_a =
    clk & bit_of(gate_sys_ff, clock_gate_pkg::CAN_A_CLOCK_ENABLE_BIT);
  assign system_clock_output_can_b =
    clk & bit_of(gate_sys_ff, clock_gate_pkg::CAN_B_CLOCK_ENABLE_BIT);

  // cycle counter for read-modify-write span checking
  logic [3:0] rmw_cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rmw_cnt_ff <= 4'h0;
    end else if (state_ff == clock_gate_pkg::ST_IDLE && bus_req.rd) begin
      rmw_cnt_ff <= 4'h1;
    end else if (rmw_cnt_ff != 4'h0 && rmw_cnt_ff != 4'hF) begin
      rmw_cnt_ff <= rmw_cnt_ff + 4'h1;
    end
  end

  property p_read_three;
    @(posedge clk) disable iff (rst)
      (state_ff == clock_gate_pkg::ST_IDLE && bus_req.rd)
        |=> !bus_rsp.ready ##1 !bus_rsp.ready ##1 bus_rsp.ready;
  endproperty
  a_read_three: assert property (p_read_three) else $error("read not three cycles");

  property p_write_one;
    @(posedge clk) disable iff (rst)
      (state_ff == clock_gate_pkg::ST_IDLE && !bus_req.rd && bus_req.wr)
        |=> bus_rsp.ready ##1 (state_ff == clock_gate_pkg::ST_IDLE);
  endproperty
  a_write_one: assert property (p_write_one) else $error("write not one cycle");

  property p_locked;
    @(posedge clk) disable iff (rst)
      !unlocked_ff |=> $stable(enable_ff);
  endproperty
  a_locked: assert property (p_locked) else $error("protected register changed");

  property p_release;
    @(posedge clk) disable iff (rst)
      protection_release |=> write_unlocked;
  endproperty
  a_release: assert property (p_release) else $error("release not taken");

  property p_restore;
    @(posedge clk) disable iff (rst)
      (protection_restore && !protection_release) |=> !write_unlocked;
  endproperty
  a_restore: assert property (p_restore) else $error("restore not taken");

  property p_reserved;
    @(posedge clk) disable iff (rst)
      (enable_ff & ~clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_write_takes;
    @(posedge clk) disable iff (rst)
      write_ok |=> enable_ff == ($past(bus_req.wdata) & clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("write lost");

  property p_rmw_six;
    @(posedge clk) disable iff (rst)
      (state_ff == clock_gate_pkg::ST_READ && bus_rsp.ready)
        ##1 (state_ff == clock_gate_pkg::ST_IDLE)
        ##1 (state_ff == clock_gate_pkg::ST_IDLE && bus_req.wr)
        |=> (bus_rsp.ready && rmw_cnt_ff == 4'h6);
  endproperty
  a_rmw_six: assert property (p_rmw_six) else $error("rmw order broken");

  property p_gate_low;
    @(negedge clk) disable iff (rst)
      !$past(enable_ff[clock_gate_pkg::CAN_A_CLOCK_ENABLE_BIT]) |-> !system_clock_output_can_a;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated clock not low");

  property p_converter_gate;
    @(negedge clk) disable iff (rst)
      converter_clock == $past(enable_ff[clock_gate_pkg::CONVERTER_CLOCK_ENABLE_BIT]);
  endproperty
  a_converter_gate: assert property (p_converter_gate) else $error("converter clock wrong");

  property p_pwm_run;
    @(negedge clk) disable iff (rst)
      pwm_timebase_clock_run == $past(enable_ff[clock_gate_pkg::PWM_TIMEBASE_CLOCK_SYNC_BIT]);
  endproperty
  a_pwm_run: assert property (p_pwm_run) else $error("time-base run wrong");

  property p_two_wire_gate;
    @(negedge clk) disable iff (rst)
      system_clock_output_two_wire_a == $past(enable_ff[clock_gate_pkg::TWO_WIRE_A_CLOCK_ENABLE_BIT]);
  endproperty
  a_two_wire_gate: assert property (p_two_wire_gate) else $error("two-wire clock wrong");

  property p_can_b_gate;
    @(negedge clk) disable iff (rst)
      system_clock_output_can_b == $past(enable_ff[clock_gate_pkg::CAN_B_CLOCK_ENABLE_BIT]);
  endproperty
  a_can_b_gate: assert property (p_can_b_gate) else $error("CAN B clock wrong");

  property p_periph_a_gate;
    @(negedge low_speed_clock) disable iff (rst)
      (!$past(rst) && !$past(rst, 2)) |-> serial_periph_a_clock ==
        $past(enable_ff[clock_gate_pkg::SERIAL_PERIPH_A_CLOCK_ENABLE_BIT], 2);
  endproperty
  a_periph_a_gate: assert property (p_periph_a_gate) else $error("periph A clock wrong");

  property p_comm_b_gate;
    @(negedge low_speed_clock) disable iff (rst)
      (!$past(rst) && !$past(rst, 2)) |-> serial_comm_b_clock ==
        $past(enable_ff[clock_gate_pkg::SERIAL_COMM_B_CLOCK_ENABLE_BIT], 2);
  endproperty
  a_comm_b_gate: assert property (p_comm_b_gate) else $error("comm B clock wrong");

  property p_read_data;
    @(posedge clk) disable iff (rst)
      (state_ff == clock_gate_pkg::ST_IDLE && bus_req.rd && hit) |=>
        bus_rsp.rdata == ($past(enable_ff) & clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

endmodule

`default_nettype wire

// >>> test/cpu_rmw_model.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_rmw_model (
  input  wire logic                        clk,
  input  wire clock_gate_pkg::bus_rsp_type bus_rsp,
  output var  clock_gate_pkg::bus_req_type bus_req,
  output var  logic                        protection_release,
  output var  logic                        protection_restore
);
  initial begin
    bus_req = '{rd: 1'b0, wr: 1'b0, addr: 6'h00, wdata: 16'h0000};
    protection_release = 1'b0;
    protection_restore = 1'b0;
  end

  task automatic access(input logic rd, input logic [5:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output int cycles);
    logic seen;
    // Let an edge pass so a request never lands in the step of the last release
    @(posedge clk);
    #1;
    bus_req = '{rd: rd, wr: ~rd, addr: addr, wdata: wdata};
    cycles = 0;
    @(posedge clk);
    // Ready is combinational, so look at it mid-cycle rather than racing the edge
    do begin
      @(negedge clk);
      cycles++;
      seen = bus_rsp.ready;
      rdata = bus_rsp.rdata;
      @(posedge clk);
    end while (seen !== 1'b1 && cycles < 8);
    #1;
    // Released lines carry the inverse so stale data cannot pass
    bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask

  task automatic rmw(input logic [15:0] and_m, input logic [15:0] or_m, output int cycles);
    logic [15:0] v;
    int          c;
    access(1'b1, clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_OFFSET, 16'h0000, v, cycles);
    // Latch and execute: the write's leading edge plus its taking edge
    access(1'b0, clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_OFFSET, (v & and_m) | or_m, v, c);
    cycles = cycles + 2 + c;
  endtask

  task automatic pulse(input logic rel);
    protection_release = rel;
    protection_restore = ~rel;
    @(posedge clk);
    #1;
    protection_release = 1'b0;
    protection_restore = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> test/test_peripheral_clock_gating_register.sv
`timescale 1ns/1ns
`default_nettype none

module test_peripheral_clock_gating_register;
  localparam logic [5:0]  REG_ADDR = clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_OFFSET;
  localparam logic [15:0] MASK     = clock_gate_pkg::PERIPHERAL_CLOCK_ENABLE_0_WMASK;

  logic                        clk;
  logic                        rst;
  logic                        low_speed_clock;
  logic                        protection_release;
  logic                        protection_restore;
  clock_gate_pkg::bus_req_type bus_req;
  clock_gate_pkg::bus_rsp_type bus_rsp;
  logic                        write_unlocked;
  wire logic [15:0]            gated;
  int                          error_cnt;
  int                          checks_done;
  int                          cyc;
  int                          n;
  logic [15:0]                 v;

  // Unused positions stay zero so the map compares against the writable mask
  assign gated[1:0]   = 2'b00;
  assign gated[5]     = 1'b0;
  assign gated[13:12] = 2'b00;

  peripheral_clock_gating_register dut (
    .clk                            (clk),
    .rst                            (rst),
    .low_speed_clock                (low_speed_clock),
    .protection_release             (protection_release),
    .protection_restore             (protection_restore),
    .bus_req                        (bus_req),
    .bus_rsp                        (bus_rsp),
    .write_unlocked                 (write_unlocked),
    .system_clock_output_can_a      (gated[14]),
    .system_clock_output_can_b      (gated[15]),
    .system_clock_output_two_wire_a (gated[4]),
    .converter_clock                (gated[3]),
    .pwm_timebase_clock_run         (gated[2]),
    .serial_periph_a_clock          (gated[8]),
    .serial_periph_b_clock          (gated[9]),
    .serial_periph_c_clock          (gated[6]),
    .serial_periph_d_clock          (gated[7]),
    .serial_comm_a_clock            (gated[10]),
    .serial_comm_b_clock            (gated[11])
  );

  cpu_rmw_model cpu (
    .clk                (clk),
    .bus_rsp            (bus_rsp),
    .bus_req            (bus_req),
    .protection_release (protection_release),
    .protection_restore (protection_restore)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Slow clock moves on the falling edge so it never races a register update
  always @(negedge clk) begin
    low_speed_clock <= ~low_speed_clock;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h got %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    cpu.access(1'b0, a, d, v, n);
  endtask

  task automatic rd_chk(input string name, input logic [5:0] a, input logic [15:0] exp);
    cpu.access(1'b1, a, 16'h0000, v, n);
    check(name, exp, v);
  endtask

  // Samples only while both clocks are high, so a gated output shows its enable
  task automatic check_clocks(input logic [15:0] en);
    logic [15:0] seen;
    seen = 16'h0000;
    repeat (3) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      #10;
      if (low_speed_clock === 1'b1) seen = seen | gated;
    end
    check("gated clocks", en & MASK, seen);
    @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    low_speed_clock = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rd_chk("reset value", REG_ADDR, 16'h0000);
    check("read cycles", 16'h0003, 16'(n));
    check("locked", 16'h0000, {15'h0000, write_unlocked});
    check_clocks(16'h0000);
    wr(REG_ADDR, 16'hFFFF);
    check("write cycles", 16'h0001, 16'(n));
    rd_chk("locked write", REG_ADDR, 16'h0000);
    $display("test locked done");
    cpu.pulse(1'b1);
    check("unlocked", 16'h0001, {15'h0000, write_unlocked});
    wr(REG_ADDR, 16'hFFFF);
    rd_chk("reserved bits", REG_ADDR, MASK);
    check_clocks(16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      wr(REG_ADDR, 16'h0001 << i);
      rd_chk("bit map", REG_ADDR, (16'h0001 << i) & MASK);
      check_clocks(16'h0001 << i);
    end
    $display("test bit map done");
    wr(REG_ADDR, 16'h0008);
    cpu.rmw(16'hFFFF, 16'h0010, n);
    check("rmw cycles", 16'h0006, 16'(n));
    cpu.rmw(16'hFFF7, 16'h0000, n);
    rd_chk("rmw result", REG_ADDR, 16'h0010);
    rd_chk("unmapped read", 6'h1D, 16'h0000);
    wr(6'h1D, 16'hFFFF);
    rd_chk("unmapped write", REG_ADDR, 16'h0010);
    $display("test rmw done");
    cpu.pulse(1'b0);
    check("relocked", 16'h0000, {15'h0000, write_unlocked});
    wr(REG_ADDR, 16'h0000);
    rd_chk("relocked write", REG_ADDR, 16'h0010);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rd_chk("second reset", REG_ADDR, 16'h0000);
    $display("test relock and reset done");
    complete_run();
  end
endmodule

`default_nettype wire
